// ---- src/lsc_pkg.sv ----
// Shared constants, state codes and carrier structs of the load shedding controller
package lsc_pkg;

    localparam int NUM_LOADS  = 6;
    localparam int LOAD_IDX_W = 3;
    localparam int AMP_W      = 8;
    localparam int ORDER_W    = NUM_LOADS * LOAD_IDX_W;
    localparam int ADDR_W     = 8;

    localparam logic [AMP_W-1:0] LIMIT_30A_AMPS = 8'h1E;
    localparam logic [AMP_W-1:0] LIMIT_20A_AMPS = 8'h14;
    localparam logic             LIMIT20_RST    = 1'b0;

    localparam longint CLK_FREQ_HZ       = 100_000_000;
    localparam longint SHED_HOLD_TIME_S  = 120;
    localparam logic [33:0] SHED_HOLD_CYCLES = 34'(SHED_HOLD_TIME_S * CLK_FREQ_HZ);
    localparam longint CLASSIFY_TIME_NS  = 1000;
    localparam logic [7:0] CLASSIFY_CYCLES =
        8'((CLASSIFY_TIME_NS * CLK_FREQ_HZ + 64'd999_999_999) / 64'd1_000_000_000);

    localparam logic [ADDR_W-1:0] REG_CTRL_OFS    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CURRENT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_ORDER_OFS   = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_LOAD0_OFS   = 8'h10;
    localparam logic [ADDR_W-1:0] REG_LOAD5_OFS   = 8'h24;

    localparam int CTRL_SELECT_BIT    = 0;
    localparam int STATUS_STATE_LSB   = 0;
    localparam int STATUS_LIMIT20_BIT = 4;
    localparam int STATUS_COUNT_LSB   = 8;
    localparam int STATUS_RELAY_LSB   = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_CLASSIFY,
        ST_FULL_50A,
        ST_FULL_GEN,
        ST_MANAGE,
        ST_SETTLE
    } lsc_state_t;

    typedef struct packed {
        logic line_one_present;
        logic line_two_present;
        logic line_240v_present;
        logic generator_sense_connector;
        logic service_select;
    } lsc_sense_t;

    typedef struct packed {
        logic                 meter_blank;
        logic [AMP_W-1:0]     meter_amps;
        logic                 ind_50a;
        logic                 ind_gen;
        logic                 ind_shore;
        logic                 ind_limit_30;
        logic [NUM_LOADS-1:0] status_led;
    } lsc_disp_t;

endpackage

// ---- src/lsc_load_mem.sv ----
// Learned per-load current store with two registered read ports
`timescale 1ns/10ps
module lsc_load_mem (
    input  wire  logic                              aclk,
    input  wire  logic                              aresetn,
    input  wire  logic                              we,
    input  wire  logic [lsc_pkg::LOAD_IDX_W-1:0]    waddr,
    input  wire  logic [lsc_pkg::AMP_W-1:0]         wdata,
    input  wire  logic [lsc_pkg::LOAD_IDX_W-1:0]    raddr_a,
    output logic       [lsc_pkg::AMP_W-1:0]         rdata_a,
    input  wire  logic [lsc_pkg::LOAD_IDX_W-1:0]    raddr_b,
    output logic       [lsc_pkg::AMP_W-1:0]         rdata_b
);
    logic [lsc_pkg::AMP_W-1:0] word_ff [0:lsc_pkg::NUM_LOADS-1];

    genvar i;
    generate
        for (i = 0; i < lsc_pkg::NUM_LOADS; i++)
        begin : g_word
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    word_ff[i] <= 8'h00;
                else if (we && waddr == 3'(i))
                    word_ff[i] <= wdata;
            end
        end
    endgenerate

    // Out-of-range addresses read zero rather than indexing past the array
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata_a <= 8'h00;
            rdata_b <= 8'h00;
        end
        else
        begin
            rdata_a <= (raddr_a < 3'(lsc_pkg::NUM_LOADS)) ? word_ff[raddr_a] : 8'h00;
            rdata_b <= (raddr_b < 3'(lsc_pkg::NUM_LOADS)) ? word_ff[raddr_b] : 8'h00;
        end
    end
endmodule

// ---- src/lsc_top.sv ----
// Load shedding controller: source classification, shedding, restore, AXI4-Lite registers
// Function
// - No line power: switch off, open all relays
// - Power appears: wake, classify before managing
// - 240 V service: management off, relays closed
// - 50 A mode: blank meter, 50 A lamp, all
// - Both 120 V with generator: all relays closed
// - Generator mode: show current, generator lamp, all
// - Both 120 V, no generator: managed shore
// - Select press changes limit; 20 A manual only
// - Threshold 30/20 A, shore service only
// - Managed entry: all relays closed, monitor current
// - Over limit: open next load in order
// - Relearn load current as drop on shed
// - Keep shedding until at or under limit or all
// - Restore last shed if spare covers it
// - Shed load stays off two minutes minimum, unless reclassification closes all
// - Six independent relay outputs
// - Limit resets to 30 A, press toggles
// - 30/20 lamp lit at 30 A
`timescale 1ns/10ps
module lsc_top #(
    parameter logic [33:0] SHED_HOLD_CYCLES = lsc_pkg::SHED_HOLD_CYCLES
) (
    input  wire  logic                              aclk,
    input  wire  logic                              aresetn,
    input  wire  lsc_pkg::lsc_sense_t               sense,
    input  wire  logic [lsc_pkg::AMP_W-1:0]         sample_amps,
    input  wire  logic                              sample_valid,
    input  wire  logic [lsc_pkg::ORDER_W-1:0]       shed_order,
    output logic       [lsc_pkg::NUM_LOADS-1:0]     relay_en,
    output logic                                    power_hold,
    output lsc_pkg::lsc_disp_t                      disp,
    input  wire  logic [lsc_pkg::ADDR_W-1:0]        awaddr,
    input  wire  logic                              awvalid,
    output logic                                    awready,
    input  wire  logic [31:0]                       wdata,
    input  wire  logic [3:0]                        wstrb,
    input  wire  logic                              wvalid,
    output logic                                    wready,
    output logic [1:0]                              bresp,
    output logic                                    bvalid,
    input  wire  logic                              bready,
    input  wire  logic [lsc_pkg::ADDR_W-1:0]        araddr,
    input  wire  logic                              arvalid,
    output logic                                    arready,
    output logic [31:0]                             rdata,
    output logic [1:0]                              rresp,
    output logic                                    rvalid,
    input  wire  logic                              rready
);
    localparam int NL = lsc_pkg::NUM_LOADS;

    // Pin synchroniser: a change is accepted once stages two and three agree
    logic [4:0]          sync1_ff;
    logic [4:0]          sync2_ff;
    logic [4:0]          sync3_ff;
    logic [4:0]          clean_ff;
    logic [4:0]          nxt_clean;
    lsc_pkg::lsc_sense_t pin;
    logic                sel_prev_ff;
    logic                limit20_ff;
    logic                sw_toggle;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_sync
            assign nxt_clean[gi] = (sync2_ff[gi] == sync3_ff[gi]) ? sync3_ff[gi] : clean_ff[gi];
        end
    endgenerate
    assign pin = clean_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_ff <= 5'h00;
            sync2_ff <= 5'h00;
            sync3_ff <= 5'h00;
            clean_ff <= 5'h00;
        end
        else
        begin
            sync1_ff <= sense;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            clean_ff <= nxt_clean;
        end
    end

    // Service limit: 30 A after reset, a press or software pulse toggles; both in one cycle toggle once
    wire sel_press = pin.service_select & ~sel_prev_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel_prev_ff <= 1'b0;
            limit20_ff  <= lsc_pkg::LIMIT20_RST;
        end
        else
        begin
            sel_prev_ff <= pin.service_select;
            limit20_ff  <= limit20_ff ^ (sel_press | sw_toggle);
        end
    end

    // Source classification
    wire any_line = pin.line_one_present | pin.line_two_present;
    wire both_line = pin.line_one_present & pin.line_two_present;
    wire cls_50a = both_line & pin.line_240v_present;
    wire cls_gen = both_line & ~pin.line_240v_present & pin.generator_sense_connector;
    lsc_pkg::lsc_state_t target;
    assign target = !any_line ? lsc_pkg::ST_OFF :
                    cls_50a   ? lsc_pkg::ST_FULL_50A :
                    cls_gen   ? lsc_pkg::ST_FULL_GEN :
                                lsc_pkg::ST_MANAGE;

    lsc_pkg::lsc_state_t       state_ff;
    lsc_pkg::lsc_state_t       nxt_state;
    lsc_pkg::lsc_state_t       cls_seen_ff;
    logic [7:0]                cls_cnt_ff;
    logic [NL-1:0]             relay_ff;
    logic [NL-1:0]             nxt_relay;
    logic [2:0]                shed_cnt_ff;
    logic [2:0]                nxt_shed_cnt;
    logic [7:0]                pre_amps_ff;
    logic [7:0]                cur_amps_ff;
    logic [2:0]                ord [0:NL-1];
    logic [NL-1:0]             hold_start;
    logic [NL-1:0]             hold_done;
    logic [33:0]               hold_cnt_ff [0:NL-1];
    logic                      mem_we;
    logic [7:0]                mem_wdata;
    logic [7:0]                learned_a;
    logic [7:0]                learned_b;
    logic [2:0]                rd_addr_q_ff;
    logic [2:0]                load_rd_idx;

    generate
        for (gi = 0; gi < NL; gi++)
        begin : g_load
            assign ord[gi] = shed_order[gi*3 +: 3];
            assign hold_done[gi] = (hold_cnt_ff[gi] == 34'h0);
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    hold_cnt_ff[gi] <= 34'h0;
                else if (hold_start[gi])
                    hold_cnt_ff[gi] <= SHED_HOLD_CYCLES;
                else if (!hold_done[gi])
                    hold_cnt_ff[gi] <= hold_cnt_ff[gi] - 34'h1;
            end
        end
    endgenerate

    wire [7:0] limit = limit20_ff ? lsc_pkg::LIMIT_20A_AMPS : lsc_pkg::LIMIT_30A_AMPS;
    wire over  = sample_amps > limit;
    wire under = sample_amps < limit;
    wire [7:0] spare = limit - sample_amps;
    wire [2:0] next_slot = (shed_cnt_ff < 3'(NL)) ? ord[shed_cnt_ff] : ord[0];
    wire [2:0] last_slot = (shed_cnt_ff != 3'h0) ? ord[shed_cnt_ff - 3'h1] : ord[0];
    wire [7:0] drop = (pre_amps_ff > sample_amps) ? pre_amps_ff - sample_amps : 8'h00;
    // Learned value is one cycle behind a change of the last shed slot
    wire learned_ok = (rd_addr_q_ff == last_slot);
    wire cls_stable = (target == cls_seen_ff);

    always_comb
    begin
        nxt_state    = state_ff;
        nxt_relay    = relay_ff;
        nxt_shed_cnt = shed_cnt_ff;
        hold_start   = '0;
        mem_we       = 1'b0;
        mem_wdata    = drop;
        if (target == lsc_pkg::ST_OFF)
        begin
            nxt_state = lsc_pkg::ST_OFF;
            nxt_relay = '0;
        end
        else
        begin
            case (state_ff)
                lsc_pkg::ST_OFF:
                    nxt_state = lsc_pkg::ST_CLASSIFY;
                lsc_pkg::ST_CLASSIFY:
                begin
                    nxt_relay = '0;
                    if (cls_stable && cls_cnt_ff == 8'h00)
                    begin
                        nxt_state    = target;
                        nxt_relay    = '1;
                        nxt_shed_cnt = 3'h0;
                    end
                end
                lsc_pkg::ST_FULL_50A, lsc_pkg::ST_FULL_GEN:
                begin
                    nxt_relay = '1;
                    if (target != state_ff)
                        nxt_state = lsc_pkg::ST_CLASSIFY;
                end
                lsc_pkg::ST_MANAGE:
                begin
                    if (target != lsc_pkg::ST_MANAGE)
                        nxt_state = lsc_pkg::ST_CLASSIFY;
                    else if (sample_valid && over && shed_cnt_ff < 3'(NL))
                    begin
                        nxt_relay[next_slot]  = 1'b0;
                        hold_start[next_slot] = 1'b1;
                        nxt_state             = lsc_pkg::ST_SETTLE;
                    end
                    else if (sample_valid && under && shed_cnt_ff != 3'h0 && learned_ok
                             && hold_done[last_slot] && spare >= learned_a)
                    begin
                        nxt_relay[last_slot] = 1'b1;
                        nxt_shed_cnt         = shed_cnt_ff - 3'h1;
                    end
                end
                lsc_pkg::ST_SETTLE:
                begin
                    if (target != lsc_pkg::ST_MANAGE)
                        nxt_state = lsc_pkg::ST_CLASSIFY;
                    else if (sample_valid)
                    begin
                        mem_we       = 1'b1;
                        nxt_shed_cnt = shed_cnt_ff + 3'h1;
                        nxt_state    = lsc_pkg::ST_MANAGE;
                    end
                end
                default:
                    nxt_state = lsc_pkg::ST_OFF;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff     <= lsc_pkg::ST_OFF;
            cls_seen_ff  <= lsc_pkg::ST_OFF;
            cls_cnt_ff   <= lsc_pkg::CLASSIFY_CYCLES;
            relay_ff     <= '0;
            shed_cnt_ff  <= 3'h0;
            pre_amps_ff  <= 8'h00;
            cur_amps_ff  <= 8'h00;
            rd_addr_q_ff <= 3'h0;
        end
        else
        begin
            state_ff     <= nxt_state;
            relay_ff     <= nxt_relay;
            shed_cnt_ff  <= nxt_shed_cnt;
            cls_seen_ff  <= target;
            rd_addr_q_ff <= last_slot;
            // Classification restarts its settle count whenever the source changes
            if (state_ff != lsc_pkg::ST_CLASSIFY || !cls_stable)
                cls_cnt_ff <= lsc_pkg::CLASSIFY_CYCLES;
            else if (cls_cnt_ff != 8'h00)
                cls_cnt_ff <= cls_cnt_ff - 8'h01;
            if (sample_valid)
                cur_amps_ff <= sample_amps;
            if (hold_start != '0)
                pre_amps_ff <= sample_amps;
        end
    end

    lsc_load_mem u_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (mem_we),
        .waddr   (next_slot),
        .wdata   (mem_wdata),
        .raddr_a (last_slot),
        .rdata_a (learned_a),
        .raddr_b (load_rd_idx),
        .rdata_b (learned_b)
    );

    // Outputs and display commands, all registered
    lsc_pkg::lsc_disp_t nxt_disp;
    wire is_50a = (state_ff == lsc_pkg::ST_FULL_50A);
    wire is_gen = (state_ff == lsc_pkg::ST_FULL_GEN);
    wire is_shore = (state_ff == lsc_pkg::ST_MANAGE) || (state_ff == lsc_pkg::ST_SETTLE);
    wire is_on = (state_ff != lsc_pkg::ST_OFF);
    assign nxt_disp.meter_blank  = is_50a | ~is_on;
    assign nxt_disp.meter_amps   = (is_gen | is_shore) ? cur_amps_ff : 8'h00;
    assign nxt_disp.ind_50a      = is_50a;
    assign nxt_disp.ind_gen      = is_gen;
    assign nxt_disp.ind_shore    = is_shore;
    assign nxt_disp.ind_limit_30 = is_on & ~limit20_ff;
    assign nxt_disp.status_led   = (is_50a | is_gen) ? '1 : relay_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            disp       <= '0;
            relay_en   <= '0;
            power_hold <= 1'b0;
        end
        else
        begin
            disp       <= nxt_disp;
            relay_en   <= relay_ff;
            power_hold <= is_on;
        end
    end

    // AXI4-Lite slave
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a <= lsc_pkg::REG_LOAD5_OFS);
    endfunction

    logic       aw_have_ff;
    logic       w_have_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic       wstrb0_ff;
    logic [7:0] rd_addr_ff;
    logic [1:0] rd_phase_ff;
    logic       rd_busy_ff;

    wire aw_hs = awvalid & awready;
    wire w_hs  = wvalid & wready;
    wire aw_full = aw_have_ff | aw_hs;
    wire w_full  = w_have_ff | w_hs;
    wire do_write = aw_full & w_full;
    wire [7:0] wr_a = aw_hs ? awaddr : awaddr_ff;
    wire [31:0] wr_d = w_hs ? wdata : wdata_ff;
    wire wr_s0 = w_hs ? wstrb[0] : wstrb0_ff;
    wire nxt_aw_have = aw_full & ~do_write;
    wire nxt_w_have = w_full & ~do_write;
    wire nxt_bvalid = do_write | (bvalid & ~bready);
    assign sw_toggle = do_write & (wr_a == lsc_pkg::REG_CTRL_OFS) & wr_s0
                       & wr_d[lsc_pkg::CTRL_SELECT_BIT];

    wire ar_hs = arvalid & arready;
    wire rd_done = rvalid & rready;
    wire nxt_rd_busy = ar_hs | (rd_busy_ff & ~rd_done);
    wire [7:0] load_ofs = rd_addr_ff - lsc_pkg::REG_LOAD0_OFS;
    assign load_rd_idx = load_ofs[4:2];

    logic [31:0] status_word;
    logic [31:0] rd_word;
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[lsc_pkg::STATUS_STATE_LSB +: 3] = 3'(state_ff);
        status_word[lsc_pkg::STATUS_LIMIT20_BIT] = limit20_ff;
        status_word[lsc_pkg::STATUS_COUNT_LSB +: 3] = shed_cnt_ff;
        status_word[lsc_pkg::STATUS_RELAY_LSB +: NL] = relay_ff;
        case (rd_addr_ff)
            lsc_pkg::REG_CTRL_OFS:    rd_word = {31'h0, limit20_ff};
            lsc_pkg::REG_STATUS_OFS:  rd_word = status_word;
            lsc_pkg::REG_CURRENT_OFS: rd_word = {24'h0, cur_amps_ff};
            lsc_pkg::REG_ORDER_OFS:   rd_word = {14'h0, shed_order};
            default:                  rd_word = addr_ok(rd_addr_ff) ? {24'h0, learned_b} : 32'h0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_ff  <= 1'b0;
            w_have_ff   <= 1'b0;
            awaddr_ff   <= 8'h00;
            wdata_ff    <= 32'h0;
            wstrb0_ff   <= 1'b0;
            awready     <= 1'b0;
            wready      <= 1'b0;
            bvalid      <= 1'b0;
            bresp       <= lsc_pkg::RESP_OKAY;
            arready     <= 1'b0;
            rd_busy_ff  <= 1'b0;
            rd_phase_ff <= 2'h0;
            rd_addr_ff  <= 8'h00;
            rvalid      <= 1'b0;
            rdata       <= 32'h0;
            rresp       <= lsc_pkg::RESP_OKAY;
        end
        else
        begin
            aw_have_ff <= nxt_aw_have;
            w_have_ff  <= nxt_w_have;
            if (aw_hs)
                awaddr_ff <= awaddr;
            if (w_hs)
            begin
                wdata_ff  <= wdata;
                wstrb0_ff <= wstrb[0];
            end
            awready <= ~nxt_aw_have & ~nxt_bvalid;
            wready  <= ~nxt_w_have & ~nxt_bvalid;
            bvalid  <= nxt_bvalid;
            if (do_write)
                bresp <= addr_ok(wr_a) ? lsc_pkg::RESP_OKAY : lsc_pkg::RESP_SLVERR;
            rd_busy_ff <= nxt_rd_busy;
            arready    <= ~nxt_rd_busy;
            if (ar_hs)
                rd_addr_ff <= araddr;
            // Two cycles after the address so the learned value port has settled
            if (ar_hs)
                rd_phase_ff <= 2'h1;
            else if (rd_phase_ff == 2'h1)
                rd_phase_ff <= 2'h2;
            else if (rd_phase_ff == 2'h2)
                rd_phase_ff <= 2'h0;
            if (rd_phase_ff == 2'h2)
            begin
                rvalid <= 1'b1;
                rdata  <= rd_word;
                rresp  <= addr_ok(rd_addr_ff) ? lsc_pkg::RESP_OKAY : lsc_pkg::RESP_SLVERR;
            end
            else if (rd_done)
                rvalid <= 1'b0;
        end
    end
endmodule

// ---- verification/lsc_top_properties.sv ----
// Port-level assertions for the load shedding controller
`timescale 1ns/10ps
module lsc_top_properties #(parameter logic [33:0] SHED_HOLD_CYCLES = 34'h0C8) (
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire lsc_pkg::lsc_sense_t sense,
    input wire logic [7:0]          sample_amps,
    input wire logic                sample_valid,
    input wire logic [5:0]          relay_en,
    input wire logic                power_hold,
    input wire lsc_pkg::lsc_disp_t  disp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Limit taken from the lamp, so a toggle shows up on the same register stage
    wire [7:0] lim = disp.ind_limit_30 ? lsc_pkg::LIMIT_30A_AMPS : lsc_pkg::LIMIT_20A_AMPS;
    sequence s_dark; (!sense.line_one_present && !sense.line_two_present) [*8]; endsequence
    sequence s_shore; disp.ind_shore [*2]; endsequence
    a_off_dark: assert property (s_dark |-> ##2 !power_hold && relay_en == 6'h00)
        else $error("powered without line input");
    a_full_relays: assert property (disp.ind_50a |-> relay_en == 6'h3F)
        else $error("relay open in 50 A mode");
    a_full_panel: assert property (disp.ind_50a |-> disp.meter_blank && &disp.status_led)
        else $error("panel wrong in 50 A mode");
    a_gen_full: assert property (
        disp.ind_gen |-> &relay_en && &disp.status_led && !disp.meter_blank)
        else $error("generator mode not full");
    a_shore_leds: assert property (disp.ind_shore |-> disp.status_led == relay_en)
        else $error("status lamps differ from relays");
    a_shore_entry: assert property ($rose(disp.ind_shore) |-> relay_en == 6'h3F)
        else $error("shore entry with relay open");
    a_shed_cause: assert property (
        s_shore ##0 (|($past(relay_en) & ~relay_en))
        |-> $past(sample_valid, 2) && $past(sample_amps, 2) > lim)
        else $error("load shed without excess sample");
    a_restore_room: assert property (
        s_shore ##0 (|(relay_en & ~$past(relay_en)))
        |-> $past(sample_valid, 2) && $past(sample_amps, 2) < lim)
        else $error("load restored without room");
    a_one_step: assert property (s_shore |-> $countones($past(relay_en) ^ relay_en) <= 1)
        else $error("several relays moved at once");
endmodule
bind lsc_top lsc_top_properties #(.SHED_HOLD_CYCLES(SHED_HOLD_CYCLES)) u_props (.aclk(aclk),
    .aresetn(aresetn), .sense(sense), .sample_amps(sample_amps), .sample_valid(sample_valid),
    .relay_en(relay_en), .power_hold(power_hold), .disp(disp));

// ---- verification/lsc_sensor_model.sv ----
// Neutral current front end: strobed samples of base plus closed loads
`timescale 1ns/10ps
module lsc_sensor_model (
    input  wire  logic       aclk,
    input  wire  logic       aresetn,
    input  wire  logic [5:0] relay_en,
    input  wire  logic [7:0] base_amps,
    output logic       [7:0] sample_amps,
    output logic             sample_valid
);
    logic [2:0] tick_ff;
    // Load on relay k draws 6+k amps; the bench model relies on the same figures
    function automatic logic [7:0] amps(input logic [5:0] on);
        amps = base_amps;
        for (int k = 0; k < 6; k++) amps += on[k] ? 8'(6 + k) : 8'h00;
    endfunction
    always_ff @(posedge aclk)
    begin
        tick_ff <= aresetn ? tick_ff + 3'h1 : 3'h0;
        sample_valid <= aresetn && tick_ff == 3'h7;
        sample_amps <= !aresetn ? 8'h00 : (tick_ff == 3'h7) ? amps(relay_en) : sample_amps;
    end
endmodule

// ---- verification/lsc_top_tb.sv ----
// Self-checking bench for the load shedding controller
`timescale 1ns/10ps
module lsc_top_tb;
    logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid;
    logic        sample_valid, power_hold;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, base_amps = 8'h00, sample_amps;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [5:0]  relay_en, mrel = 6'h3F;
    logic [17:0] shed_order = 18'h0;
    lsc_pkg::lsc_sense_t sense = 5'h00;
    lsc_pkg::lsc_disp_t  disp;
    int          n_errors = 0, tests_run = 0, base, j, ord[6], q[$];
    lsc_top #(.SHED_HOLD_CYCLES(34'h7D0)) dut (.aclk, .aresetn, .sense, .sample_amps,
        .sample_valid, .shed_order, .relay_en, .power_hold, .disp, .awaddr, .awvalid, .awready,
        .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);
    lsc_sensor_model u_sensor (.aclk, .aresetn, .relay_en, .base_amps, .sample_amps,
        .sample_valid);
    always #5 aclk = ~aclk;
    task automatic final_report();
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %0t %h %h", $time, g, e);
        end
    endtask
    // Every handshake and settle wait passes here, so a hang ends the run as a failure
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        n_errors += (n > 5000);
        if (n > 5000) final_report();
    endtask
    task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        int n = 0;
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= {3{wr}};
        {arvalid, rready} <= {2{!wr}};
        do
        begin
            tick(n);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (arready) arvalid <= 1'h0;
        end
        while (!(wr ? bvalid : rvalid));
        {bready, rready} <= 2'h0;
        chk(wr ? bresp : rresp, er);
        if (!wr) chk(rdata, d);
        // One idle edge so a following call never re-drives a strobe in the same step
        tick(n);
    endtask
    function automatic int tot();
        int t = base;
        foreach (ord[i]) t += mrel[i] ? 6 + i : 0;
        return t;
    endfunction
    // Model: shed in order while over, then restore last shed while room covers it
    task automatic settle(input int lim);
        int n = 0;
        while (tot() > lim && q.size() < 6)
        begin
            q.push_back(ord[q.size()]);
            mrel[q[$]] = 1'h0;
        end
        while (q.size() > 0 && tot() < lim && lim - tot() >= 6 + q[$])
            mrel[q.pop_back()] = 1'h1;
        while (relay_en !== mrel) tick(n);
        chk({disp.ind_shore, relay_en}, {1'h1, mrel});
    endtask
    initial
    begin
        void'($urandom(19));
        ord = '{0, 1, 2, 3, 4, 5};
        for (int i = 5; i > 0; i--)
        begin
            j = $urandom % (i + 1);
            {ord[i], ord[j]} = {ord[j], ord[i]};
        end
        foreach (ord[i]) shed_order[3*i +: 3] <= 3'(ord[i]);
        base = 10 + $urandom % 10;
        base_amps <= 8'(base);
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (20) @(posedge aclk);
        chk({power_hold, relay_en}, 7'h00);
        sense <= 5'h1C;
        repeat (150) @(posedge aclk);
        chk({power_hold, relay_en}, 7'h7F);
        chk({disp.ind_50a, disp.meter_blank, disp.status_led}, 8'hFF);
        axi(1'h0, 8'h04, 32'h003F0002, 2'h0);
        sense <= 5'h1A;
        repeat (150) @(posedge aclk);
        chk({disp.ind_gen, disp.status_led, relay_en}, 13'h1FFF);
        chk(disp.meter_amps, tot());
        sense <= 5'h18;
        settle(30);
        foreach (q[i]) axi(1'h0, 8'h10 + 8'(4 * q[i]), 6 + q[i], 2'h0);
        base = 0;
        base_amps <= 8'h00;
        repeat (300) @(posedge aclk);
        chk(relay_en, mrel);
        settle(30);
        axi(1'h1, 8'h00, 32'h1, 2'h0);
        settle(20);
        chk(disp.ind_limit_30, 1'h0);
        axi(1'h0, 8'h00, 32'h1, 2'h0);
        sense <= 5'h19;
        repeat (10) @(posedge aclk);
        chk(disp.ind_limit_30, 1'h1);
        axi(1'h0, 8'h0C, 32'(shed_order), 2'h0);
        axi(1'h0, 8'h40, 32'h0, lsc_pkg::RESP_SLVERR);
        sense <= 5'h00;
        repeat (20) @(posedge aclk);
        chk({power_hold, relay_en}, 7'h00);
        final_report();
    end
endmodule
